// ---- aopc_pkg.sv ----
package aopc_pkg;
    // register indices as printed; byte address is four times the index
    localparam logic [7:0] AOPC_IDX_CTRL4 = 8'h1D;
    localparam logic [7:0] AOPC_IDX_CTRL5 = 8'h1E;
    localparam logic [7:0] AOPC_IDX_IRQ_STAT = 8'h20;
    localparam logic [7:0] AOPC_IDX_IRQ_MASK = 8'h21;
    // field positions, control register 4
    localparam int AOPC_B_DAC_STEP = 14;
    localparam int AOPC_B_ST_STEP = 13;
    localparam int AOPC_B_SHORT_DIS = 8;
    localparam int AOPC_B_SHORT_PD = 7;
    localparam int AOPC_B_SHORT_FLAG = 6;
    localparam int AOPC_B_POP_ACT = 5;
    localparam int AOPC_B_POP_SPEED = 4;
    localparam int AOPC_B_POP_LEN_LO = 2;
    // field positions, control register 5
    localparam int AOPC_B_DRIVER_POP_REDUCE_DISABLE = 2;
    localparam int AOPC_B_DRV_RAMP = 1;
    // writable masks and reset values
    localparam logic [15:0] AOPC_WMASK4 = 16'hFF9C;
    localparam logic [15:0] AOPC_WMASK5 = 16'hFFFE;
    localparam logic [15:0] AOPC_RST4 = 16'h0000;
    localparam logic [15:0] AOPC_RST5 = 16'h0000;
    // interrupt status bits
    localparam int AOPC_IRQ_SHORT = 0;
    localparam int AOPC_IRQ_POP_DONE = 1;
    localparam int AOPC_IRQ_W = 2;
    // ramp times
    localparam int AOPC_CLK_HZ = 100000000;
    localparam int AOPC_RAMP_SLOW_MS = 4000;
    localparam int AOPC_RAMP_FAST_MS = 800;
    localparam int AOPC_RAMP_VG_US = 1000;
    localparam longint AOPC_RAMP_SLOW_CYC = longint'(AOPC_RAMP_SLOW_MS) * (AOPC_CLK_HZ / 1000);
    localparam longint AOPC_RAMP_FAST_CYC = longint'(AOPC_RAMP_FAST_MS) * (AOPC_CLK_HZ / 1000);
    localparam longint AOPC_RAMP_VG_CYC = longint'(AOPC_RAMP_VG_US) * (AOPC_CLK_HZ / 1000000);
    // dac pop reduction: base length unit, in core clock cycles; speed and length code scale it
    localparam int AOPC_POP_US = 100;
    localparam int AOPC_POP_CYC = AOPC_POP_US * (AOPC_CLK_HZ / 1000000);
endpackage

// ---- aopc_ctrl.sv ----
`timescale 1ns/100ps
// Summary of operation
// - dac gain changes soft-step when dac_gain_step_disable is 0, immediate when 1.
// - sidetone gain changes soft-step when sidetone_step_disable is 0, immediate when 1.
// - short detection runs while short_detect_disable is 0, stops when 1.
// - with short_auto_powerdown set, a detected short powers drivers down.
// - short_detected_status is read-only, 1 while a short is sensed with detection on, holds while detection is off, resets to 0.
// - dac_pop_reduce_active reads whether dac pop reduction runs; resets 0.
// - dac_pop_speed_sel 0 selects fast timing, 1 slow timing.
// - dac_pop_length_sel 00 selects long, 11 short; resets 00.
// - driver pop reduction applied while driver_pop_reduce_disable is 0, bypassed when 1.
// - ramp 0.8 s or 4 s with virtual ground down, 1 ms otherwise.
// - lowest two bits of register 4 are reserved and read-only.
module aopc_ctrl import aopc_pkg::*; #(
    parameter longint RAMP_SLOW_CYC = AOPC_RAMP_SLOW_CYC,
    parameter longint RAMP_FAST_CYC = AOPC_RAMP_FAST_CYC,
    parameter longint RAMP_VG_CYC = AOPC_RAMP_VG_CYC,
    parameter int POP_UNIT_CYC = AOPC_POP_CYC
) (
    // clock and reset
    input wire logic core_clk,
    input wire logic rstn,
    // avalon-mm slave
    input wire logic [9:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    // analog side, asynchronous
    input wire logic short_sense,
    input wire logic virtual_ground_up,
    input wire logic dac_gain_change,
    input wire logic sidetone_gain_change,
    input wire logic dac_pop_start,
    // controls out
    output logic dac_gain_softstep,
    output logic sidetone_softstep,
    output logic driver_powerdown,
    output logic dac_pop_reduce_active,
    output logic driver_ramp_busy,
    output logic irq
);
    typedef struct packed {
        logic [15:0] ctrl4;
        logic [15:0] ctrl5;
        logic [1:0] mask;
        logic [1:0] stat;
        logic short_flag;
        logic pwdn;
        logic [31:0] ramp_cnt;
        logic ramp_busy;
        logic [31:0] pop_cnt;
        logic pop_act;
        logic [1:0] sync_s;
        logic [1:0] sync_v;
        logic [1:0] sync_p;
        logic p_d;
        logic ack;
        logic [31:0] rdata;
        logic dstep;
        logic sstep;
        logic irq;
    } aopc_state_s;

    aopc_state_s st_r;
    aopc_state_s st_nxt;
    logic [7:0] idx;
    logic short_det;
    logic pop_rise;
    logic [15:0] be16;
    logic [31:0] pop_len;
    logic [31:0] ramp_len;

    assign idx = avs_address[9:2];
    assign be16 = {{8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
    assign short_det = st_r.sync_s[1] & ~st_r.ctrl4[AOPC_B_SHORT_DIS];
    assign pop_rise = st_r.sync_p[1] & ~st_r.p_d;

    always_comb begin
        // pop length: speed doubles, length code scales; 00 longest, 11 shortest
        pop_len = 32'(POP_UNIT_CYC) * 32'(4 - int'(st_r.ctrl4[3:2]));
        if (st_r.ctrl4[AOPC_B_POP_SPEED]) begin
            pop_len = pop_len << 1;
        end
        if (!st_r.sync_v[1]) begin
            ramp_len = st_r.ctrl5[AOPC_B_DRV_RAMP] ? 32'(RAMP_SLOW_CYC) : 32'(RAMP_FAST_CYC);
        end else begin
            ramp_len = 32'(RAMP_VG_CYC);
        end
    end

    always_comb begin
        st_nxt = st_r;
        st_nxt.sync_s = {st_r.sync_s[0], short_sense};
        st_nxt.sync_v = {st_r.sync_v[0], virtual_ground_up};
        st_nxt.sync_p = {st_r.sync_p[0], dac_pop_start};
        st_nxt.p_d = st_r.sync_p[1];
        st_nxt.ack = 1'b0;
        // gain events registered once, without the two-stage synchronizer; softstep follows the disable bit
        st_nxt.dstep = dac_gain_change & ~st_r.ctrl4[AOPC_B_DAC_STEP];
        st_nxt.sstep = sidetone_gain_change & ~st_r.ctrl4[AOPC_B_ST_STEP];
        // flag only moves while detection enabled
        if (!st_r.ctrl4[AOPC_B_SHORT_DIS]) begin
            st_nxt.short_flag = st_r.sync_s[1];
        end
        st_nxt.pwdn = short_det & st_r.ctrl4[AOPC_B_SHORT_PD];
        // dac pop reduction timer
        if (st_r.pop_act) begin
            if (st_r.pop_cnt == 32'h0000_0000) begin
                st_nxt.pop_act = 1'b0;
                st_nxt.stat[AOPC_IRQ_POP_DONE] = 1'b1;
            end else begin
                st_nxt.pop_cnt = st_r.pop_cnt - 32'h0000_0001;
            end
        end else if (pop_rise) begin
            st_nxt.pop_act = 1'b1;
            st_nxt.pop_cnt = pop_len - 32'h0000_0001;
        end
        // driver ramp, restarted on power-up after a short power-down
        if (st_r.ramp_busy) begin
            if (st_r.ramp_cnt == 32'h0000_0000) begin
                st_nxt.ramp_busy = 1'b0;
            end else begin
                st_nxt.ramp_cnt = st_r.ramp_cnt - 32'h0000_0001;
            end
        end else if (st_r.pwdn & ~st_nxt.pwdn & ~st_r.ctrl5[AOPC_B_DRIVER_POP_REDUCE_DISABLE]) begin
            st_nxt.ramp_busy = 1'b1;
            st_nxt.ramp_cnt = ramp_len - 32'h0000_0001;
        end
        if (st_r.ctrl5[AOPC_B_DRIVER_POP_REDUCE_DISABLE]) begin
            st_nxt.ramp_busy = 1'b0;
        end
        // bus: one wait cycle, then ack; read data latched in the wait cycle
        if ((avs_read | avs_write) & ~st_r.ack) begin
            st_nxt.ack = 1'b1;
            st_nxt.rdata = 32'h0000_0000;
            if (avs_read) begin
                case (idx)
                    AOPC_IDX_CTRL4: begin
                        st_nxt.rdata = {16'h0000, st_r.ctrl4[15:7], st_r.short_flag, st_r.pop_act,
                            st_r.ctrl4[4:2], 2'b00};
                    end
                    AOPC_IDX_CTRL5: begin
                        st_nxt.rdata = {16'h0000, st_r.ctrl5[15:1], 1'b0};
                    end
                    AOPC_IDX_IRQ_STAT: begin
                        st_nxt.rdata = {30'h0000_0000, st_r.stat};
                        st_nxt.stat = 2'b00;
                    end
                    AOPC_IDX_IRQ_MASK: begin
                        st_nxt.rdata = {30'h0000_0000, st_r.mask};
                    end
                    default: begin
                    end
                endcase
            end
        end
        // write lands only at the edge that sees waitrequest low
        if (avs_write & st_r.ack) begin
            case (idx)
                    AOPC_IDX_CTRL4: begin
                        st_nxt.ctrl4 = (st_r.ctrl4 & ~(AOPC_WMASK4 & be16))
                            | (avs_writedata[15:0] & AOPC_WMASK4 & be16);
                    end
                    AOPC_IDX_CTRL5: begin
                        st_nxt.ctrl5 = (st_r.ctrl5 & ~(AOPC_WMASK5 & be16))
                            | (avs_writedata[15:0] & AOPC_WMASK5 & be16);
                    end
                    AOPC_IDX_IRQ_MASK: begin
                        if (avs_byteenable[0]) begin
                            st_nxt.mask = avs_writedata[1:0];
                        end
                    end
                    default: begin
                    end
            endcase
        end
        // events set after clear so set wins
        if (short_det & ~st_r.short_flag) begin
            st_nxt.stat[AOPC_IRQ_SHORT] = 1'b1;
        end
        if (st_r.pop_act && st_r.pop_cnt == 32'h0000_0000) begin
            st_nxt.stat[AOPC_IRQ_POP_DONE] = 1'b1;
        end
        st_nxt.irq = |(st_nxt.stat & st_nxt.mask);
    end

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            st_r <= '0;
            st_r.ctrl4 <= AOPC_RST4;
            st_r.ctrl5 <= AOPC_RST5;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign avs_readdata = st_r.rdata;
    assign avs_waitrequest = (avs_read | avs_write) & ~st_r.ack;
    assign dac_gain_softstep = st_r.dstep;
    assign sidetone_softstep = st_r.sstep;
    assign driver_powerdown = st_r.pwdn;
    assign dac_pop_reduce_active = st_r.pop_act;
    assign driver_ramp_busy = st_r.ramp_busy;
    assign irq = st_r.irq;

    // gain stepping, both directions of each disable bit
    property dstep_p;
        @(posedge core_clk) disable iff (!rstn)
        (dac_gain_change & st_r.ctrl4[AOPC_B_DAC_STEP]) |=> !dac_gain_softstep;
    endproperty
    dac_step_a: assert property (dstep_p)
        else $error("dac softstep while disabled");
    dac_step_on_a: assert property (@(posedge core_clk) disable iff (!rstn)
        (dac_gain_change & ~st_r.ctrl4[AOPC_B_DAC_STEP]) |=> dac_gain_softstep)
        else $error("dac softstep missing");
    sidetone_step_a: assert property (@(posedge core_clk) disable iff (!rstn)
        (sidetone_gain_change & ~st_r.ctrl4[AOPC_B_ST_STEP]) |=> sidetone_softstep)
        else $error("sidetone softstep missing");
    sidetone_off_a: assert property (@(posedge core_clk) disable iff (!rstn)
        (sidetone_gain_change & st_r.ctrl4[AOPC_B_ST_STEP]) |=> !sidetone_softstep)
        else $error("sidetone softstep while disabled");

    // short detection and status
    detect_off_a: assert property (@(posedge core_clk) disable iff (!rstn)
        st_r.ctrl4[AOPC_B_SHORT_DIS] |=> $stable(st_r.short_flag))
        else $error("flag moved while detection off");
    short_off_a: assert property (@(posedge core_clk) disable iff (!rstn)
        st_r.ctrl4[AOPC_B_SHORT_DIS] |=> !driver_powerdown)
        else $error("powerdown while detection off");
    auto_pd_a: assert property (@(posedge core_clk) disable iff (!rstn)
        driver_powerdown |-> $past(st_r.ctrl4[AOPC_B_SHORT_PD]))
        else $error("powerdown without enable");
    auto_pd_on_a: assert property (@(posedge core_clk) disable iff (!rstn)
        (short_det & st_r.ctrl4[AOPC_B_SHORT_PD]) |=> driver_powerdown)
        else $error("powerdown missing on short");
    short_flag_a: assert property (@(posedge core_clk) disable iff (!rstn)
        (st_r.sync_s[1] & ~st_r.ctrl4[AOPC_B_SHORT_DIS]) |=> st_r.short_flag)
        else $error("short flag not set");
    // a read-clear in the same cycle must not swallow a new short
    short_stat_a: assert property (@(posedge core_clk) disable iff (!rstn)
        (short_det & ~st_r.short_flag) |=> st_r.stat[AOPC_IRQ_SHORT])
        else $error("short status lost");

    // dac pop timer
    sequence pop_go_s;
        pop_rise && !st_r.pop_act;
    endsequence
    pop_act_a: assert property (@(posedge core_clk) disable iff (!rstn)
        pop_go_s |=> dac_pop_reduce_active)
        else $error("pop not active");
    pop_len_a: assert property (@(posedge core_clk) disable iff (!rstn)
        pop_go_s |=> st_r.pop_cnt == $past(pop_len) - 32'h0000_0001)
        else $error("pop length wrong");

    // driver ramp after a short power-down releases
    sequence ramp_go_s;
        !st_r.ramp_busy && st_nxt.ramp_busy;
    endsequence
    ramp_src_a: assert property (@(posedge core_clk) disable iff (!rstn)
        ramp_go_s |-> st_r.pwdn && !st_r.ctrl5[AOPC_B_DRIVER_POP_REDUCE_DISABLE])
        else $error("ramp without power-down release");
    ramp_len_a: assert property (@(posedge core_clk) disable iff (!rstn)
        ramp_go_s |=> st_r.ramp_cnt == $past(ramp_len) - 32'h0000_0001)
        else $error("ramp length wrong");
    ramp_vg_a: assert property (@(posedge core_clk) disable iff (!rstn)
        ramp_go_s ##0 st_r.sync_v[1] |=> st_r.ramp_cnt == 32'(RAMP_VG_CYC) - 32'h0000_0001)
        else $error("ramp not short with virtual ground up");
    drv_pop_a: assert property (@(posedge core_clk) disable iff (!rstn)
        st_r.ctrl5[AOPC_B_DRIVER_POP_REDUCE_DISABLE] |=> !driver_ramp_busy)
        else $error("ramp while bypassed");

    // register bus and interrupt
    rsvd_bits_a: assert property (@(posedge core_clk) disable iff (!rstn)
        (avs_read & ~avs_waitrequest & idx == AOPC_IDX_CTRL4) |-> avs_readdata[1:0] == 2'b00)
        else $error("reserved bits nonzero");
    wait_once_a: assert property (@(posedge core_clk) disable iff (!rstn)
        avs_waitrequest |=> st_r.ack)
        else $error("request not acknowledged");
    irq_level_a: assert property (@(posedge core_clk) disable iff (!rstn)
        irq == |(st_r.stat & st_r.mask))
        else $error("irq level wrong");
endmodule

// ---- tb.sv ----
`timescale 1ns/100ps
module tb;
    import aopc_pkg::*;
    logic core_clk = 1'b0;
    logic rstn = 1'b0;
    logic [9:0] avs_address = 10'h000;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h00000000;
    logic [3:0] avs_byteenable = 4'h3;
    logic short_sense = 1'b0;
    logic virtual_ground_up = 1'b0;
    logic dac_gain_change = 1'b0;
    logic sidetone_gain_change = 1'b0;
    logic dac_pop_start = 1'b0;
    wire logic [31:0] avs_readdata;
    wire logic avs_waitrequest, dac_gain_softstep, sidetone_softstep, driver_powerdown;
    wire logic dac_pop_reduce_active, driver_ramp_busy, irq;
    int n_fail = 0;
    int n_compared = 0;
    int n;
    logic [31:0] exp_q[$];
    logic [15:0] d;
    integer seed = 32'hAD6ABBB5;
    // ramp cases: ctrl5 value, virtual ground, cycles with the shortened parameters
    logic [15:0] ramp_cfg[4] = '{16'h0002, 16'h0000, 16'h0000, 16'h0004};
    logic ramp_vg[4] = '{1'b0, 1'b0, 1'b1, 1'b0};
    int ramp_len[4] = '{20, 10, 5, 0};

    always #5 core_clk = ~core_clk;

    aopc_ctrl #(.RAMP_SLOW_CYC(20), .RAMP_FAST_CYC(10), .RAMP_VG_CYC(5), .POP_UNIT_CYC(4)) aopc_ctrl_inst (
        .core_clk(core_clk), .rstn(rstn), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .short_sense(short_sense),
        .virtual_ground_up(virtual_ground_up), .dac_gain_change(dac_gain_change),
        .sidetone_gain_change(sidetone_gain_change), .dac_pop_start(dac_pop_start),
        .dac_gain_softstep(dac_gain_softstep), .sidetone_softstep(sidetone_softstep),
        .driver_powerdown(driver_powerdown), .dac_pop_reduce_active(dac_pop_reduce_active),
        .driver_ramp_busy(driver_ramp_busy), .irq(irq));

    task automatic conclude;
        $display("compared %0d mismatches %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask

    task automatic tally(input bit ok, input string what, input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (!ok) begin
            n_fail++;
            $display("BAD %0t %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    task automatic cmp_rd(input logic [31:0] got, input logic [31:0] exp);
        tally(got === exp, "readdata", got, exp);
    endtask

    task automatic cmp_pin(input logic [15:0] got, input logic [15:0] exp, input string what);
        tally(got === exp, what, {16'h0000, got}, {16'h0000, exp});
    endtask

    // called just after a rising edge; request held until waitrequest is seen low
    task automatic bus(input logic w, input logic [7:0] idx, input logic [15:0] wd, input logic [3:0] be);
        avs_address <= {idx, 2'b00};
        avs_read <= !w;
        avs_write <= w;
        avs_writedata <= {16'h0000, wd};
        avs_byteenable <= be;
        forever begin
            @(posedge core_clk);
            if (avs_waitrequest === 1'b0) break;
        end
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        @(posedge core_clk);
    endtask

    task automatic wr(input logic [7:0] idx, input logic [15:0] wd);
        bus(1'b1, idx, wd, 4'h3);
    endtask

    task automatic rd(input logic [7:0] idx, input logic [15:0] e);
        exp_q.push_back({16'h0000, e});
        bus(1'b0, idx, 16'h0000, 4'h3);
    endtask

    // length in cycles of the next high stretch of the ramp or pop output
    task automatic span(input bit ramp, output int len);
        len = 0;
        for (int i = 0; i < 40 && len == 0; i++) begin
            @(negedge core_clk);
            if ((ramp ? driver_ramp_busy : dac_pop_reduce_active) === 1'b1) len = 1;
        end
        while (len > 0 && len < 300) begin
            @(negedge core_clk);
            if ((ramp ? driver_ramp_busy : dac_pop_reduce_active) !== 1'b1) break;
            len++;
        end
        @(posedge core_clk);
    endtask

    // read data checked in the answer cycle, oldest note first
    always @(posedge core_clk) begin
        if (avs_read === 1'b1 && avs_waitrequest === 1'b0) begin
            if (exp_q.size() == 0) tally(1'b0, "unexpected read", avs_readdata, 32'h00000000);
            else cmp_rd(avs_readdata, exp_q.pop_front());
        end
    end

    initial begin
        #200000;
        n_fail++;
        conclude;
    end

    initial begin
        repeat (8) @(posedge core_clk);
        rstn <= 1'b1;
        @(posedge core_clk);
        rd(AOPC_IDX_CTRL4, AOPC_RST4);
        rd(AOPC_IDX_CTRL5, AOPC_RST5);
        wr(AOPC_IDX_CTRL4, 16'h61FC);
        rd(AOPC_IDX_CTRL4, 16'h619C);
        bus(1'b1, AOPC_IDX_CTRL4, 16'h0000, 4'h1);
        rd(AOPC_IDX_CTRL4, 16'h6100);
        wr(8'h1F, 16'h1234);
        rd(8'h1F, 16'h0000);
        repeat (4) begin
            d = 16'($random(seed)) & 16'h619C;
            wr(AOPC_IDX_CTRL4, d);
            rd(AOPC_IDX_CTRL4, d);
            d = 16'($random(seed)) & 16'h0006;
            wr(AOPC_IDX_CTRL5, d);
            rd(AOPC_IDX_CTRL5, d);
        end
        for (int k = 0; k < 4; k++) begin
            wr(AOPC_IDX_CTRL4, {1'b0, k[1], k[0], 13'h0000});
            dac_gain_change <= 1'b1;
            sidetone_gain_change <= 1'b1;
            @(posedge core_clk);
            dac_gain_change <= 1'b0;
            sidetone_gain_change <= 1'b0;
            @(negedge core_clk);
            cmp_pin({15'h0000, dac_gain_softstep}, {15'h0000, !k[1]}, "dac softstep");
            cmp_pin({15'h0000, sidetone_softstep}, {15'h0000, !k[0]}, "sidetone softstep");
            @(posedge core_clk);
        end
        rd(AOPC_IDX_IRQ_STAT, 16'h0000);
        wr(AOPC_IDX_IRQ_MASK, 16'h0001);
        // detection off, then on without auto power-down
        for (int k = 0; k < 2; k++) begin
            wr(AOPC_IDX_CTRL4, k ? 16'h0000 : 16'h0180);
            short_sense <= 1'b1;
            repeat (6) @(posedge core_clk);
            @(negedge core_clk);
            cmp_pin({15'h0000, driver_powerdown}, 16'h0000, "powerdown");
            cmp_pin({15'h0000, irq}, {15'h0000, k[0]}, "irq");
            @(posedge core_clk);
            rd(AOPC_IDX_CTRL4, k ? 16'h0040 : 16'h0180);
            short_sense <= 1'b0;
            repeat (6) @(posedge core_clk);
        end
        wr(AOPC_IDX_CTRL4, 16'h0080);
        for (int k = 0; k < 4; k++) begin
            wr(AOPC_IDX_CTRL5, ramp_cfg[k]);
            virtual_ground_up <= ramp_vg[k];
            short_sense <= 1'b1;
            repeat (6) @(posedge core_clk);
            @(negedge core_clk);
            cmp_pin({15'h0000, driver_powerdown}, 16'h0001, "powerdown");
            @(posedge core_clk);
            rd(AOPC_IDX_CTRL4, 16'h00C0);
            short_sense <= 1'b0;
            span(1'b1, n);
            cmp_pin(16'(n), 16'(ramp_len[k]), "ramp length");
        end
        wr(AOPC_IDX_IRQ_MASK, 16'h0000);
        @(negedge core_clk);
        cmp_pin({15'h0000, irq}, 16'h0000, "masked irq");
        @(posedge core_clk);
        rd(AOPC_IDX_IRQ_STAT, 16'h0001);
        rd(AOPC_IDX_IRQ_STAT, 16'h0000);
        // pop length: unit 4, times (4 - code), doubled when slow
        for (int k = 0; k < 4; k++) begin
            wr(AOPC_IDX_CTRL4, {11'h000, k[1], {2{k[0]}}, 2'b00});
            dac_pop_start <= 1'b1;
            @(posedge core_clk);
            dac_pop_start <= 1'b0;
            span(1'b0, n);
            cmp_pin(16'(n), 16'(4 * (4 - 3 * k[0]) * (k[1] + 1)), "pop length");
        end
        rd(AOPC_IDX_IRQ_STAT, 16'h0002);
        repeat (2) @(posedge core_clk);
        conclude;
    end
endmodule
